// [hw/scbc_pkg.sv]
// Purpose: constants and types of the system clock and boot control block
// Assumes: registers reached over a plain address / strobe port, 8-bit data
// Notes:   oscillators arrive as one-cycle tick pulses sampled on the 200 MHz clock
//
// How it works
// [R1] after power-on reset, run waits 1024 slow RC ticks
// [R2] first fetch after reset starts at program address 0x000
// [R3] crystal, fast RC, slow RC enabled by crystal bit 7, mode bits 4, 2
// [R4] after boot fast and slow RC run, crystal is off
// [R5] mode codes 34h, 14h, 3Ch pick fast RC divided by 2, 4, 8
// [R6] mode codes 1Ch, 7Ch pick fast RC divided by 16, 32
// [R7] mode code E4h picks the slow RC undivided
// [R8] trim register adjusts the fast RC, aimed at 16 MHz
// [R9] divide-by-2 option: mode 0x34 at boot, watchdog off, slow RC on, port_a_bit5 input
// [R10] fast wake from CPU halt resumes after 128 system clock periods
// [R11] fast wake from full_power_down on fast RC: settle time plus 128 periods
// [R12] normal wake from either suspend waits 1024 slow RC periods
// [R13] hardware_reset_pin must be held at least 120 us by the outside
// [R14] a mode write switches source and divider at the next boundary between whole system clock periods
// [R15] software turns the old oscillator off only in a later write
// [R16] source switching never produces a shortened system clock pulse

package scbc_pkg;

    // -----------------------------------------------------------------
    // register offsets
    // -----------------------------------------------------------------
    localparam logic [7:0] CLKMD_ADDR = 8'h03;
    localparam logic [7:0] EOSCR_ADDR = 8'h0b;
    localparam logic [7:0] IHRCR_ADDR = 8'h0c;
    localparam logic [7:0] SUSP_ADDR  = 8'h0d;
    localparam logic [7:0] STAT_ADDR  = 8'h0e;

    // -----------------------------------------------------------------
    // fields and reset values
    // -----------------------------------------------------------------
    localparam int         CLKMD_FAST_EN_BIT = 4;
    localparam int         CLKMD_SLOW_EN_BIT = 2;
    localparam int         EOSCR_XTAL_EN_BIT = 7;
    localparam int         EOSCR_DRV_LSB     = 5;
    localparam int         SUSP_HALT_BIT     = 0;
    localparam int         SUSP_PDOWN_BIT    = 1;
    localparam int         SUSP_FAST_BIT     = 2;
    localparam logic [7:0] EOSCR_RST         = 8'h00;
    localparam logic [7:0] IHRCR_RST         = 8'h80;
    localparam logic [9:0] RESET_VECTOR      = 10'h000;

    // -----------------------------------------------------------------
    // mode codes; enable bits 4 and 2 are masked before decoding
    // -----------------------------------------------------------------
    localparam logic [7:0] CLKMD_DIV2    = 8'h34;
    localparam logic [7:0] CLKMD_DIV4    = 8'h14;
    localparam logic [7:0] CLKMD_DIV8    = 8'h3c;
    localparam logic [7:0] CLKMD_DIV16   = 8'h1c;
    localparam logic [7:0] CLKMD_DIV32   = 8'h7c;
    localparam logic [7:0] CLKMD_SLOW    = 8'he4;
    localparam logic [7:0] CLKMD_SELMASK = 8'heb;
    localparam logic [7:0] CLKMD_XTALMSK = 8'he0;
    localparam logic [7:0] CLKMD_XTAL    = 8'ha0;

    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int CLOCK_MHZ          = 200;
    localparam int BOOT_SLOW_CYC      = 1024;
    localparam int WAKE_SYS_CYC       = 128;
    localparam int WAKE_SLOW_CYC      = 1024;
    localparam int FAST_RC_SETTLE_NS  = 5000;
    localparam int FAST_RC_SETTLE_CYC = (FAST_RC_SETTLE_NS * CLOCK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {SRC_FAST, SRC_SLOW, SRC_XTAL} scbc_src_e;
    typedef enum logic [2:0] {ST_BOOT, ST_RUN, ST_HALT, ST_PDOWN, ST_SETTLE, ST_WAKESYS, ST_WAKESLOW}
        scbc_state_e;

endpackage : scbc_pkg

// [hw/scbc_top.sv]
// Purpose: system clock source/divider selection, boot delay and wake-up timing
// Assumes: oscillator ticks and wake events are one-cycle pulses synchronous to clock
// Notes:   system clock leaves as a one-cycle enable pulse per period (sysClkTick)
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/100ps

module scbc_top
#(
    parameter logic [7:0] BOOT_CLKMD = scbc_pkg::CLKMD_DIV2,
    parameter int         WAIT_W     = 16
)
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // register port
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWrStb,
    input  wire logic       regRdStb,
    output logic      [7:0] regRdData,
    // oscillator ticks and wake source
    input  wire logic       fastRcTick,
    input  wire logic       slowRcTick,
    input  wire logic       crystalTick,
    input  wire logic       wakeEvent,
    // oscillator control
    output logic            fastRcEnable,
    output logic            slowRcEnable,
    output logic            crystalEnable,
    output logic      [1:0] crystalDrive,
    output logic      [7:0] fastRcTrim,
    // system side
    output logic            sysClkTick,
    output logic            cpuRun,
    output logic            fetchStart,
    output logic      [9:0] fetchAddr,
    output logic            wdtEnable,
    output logic            portA5Input
);

    // -----------------------------------------------------------------
    // mode decode: {valid, source, log2 divider}
    // -----------------------------------------------------------------
    function automatic logic [5:0] decodeMode(input logic [7:0] code);
        logic [7:0] m;
        m = code & scbc_pkg::CLKMD_SELMASK;
        decodeMode = 6'h00;
        if (m == (scbc_pkg::CLKMD_DIV2 & scbc_pkg::CLKMD_SELMASK))
            decodeMode = {1'b1, scbc_pkg::SRC_FAST, 3'd1}; // R5
        else if (m == (scbc_pkg::CLKMD_DIV4 & scbc_pkg::CLKMD_SELMASK))
            decodeMode = {1'b1, scbc_pkg::SRC_FAST, 3'd2}; // R5
        else if (m == (scbc_pkg::CLKMD_DIV8 & scbc_pkg::CLKMD_SELMASK))
            decodeMode = {1'b1, scbc_pkg::SRC_FAST, 3'd3}; // R5
        else if (m == (scbc_pkg::CLKMD_DIV16 & scbc_pkg::CLKMD_SELMASK))
            decodeMode = {1'b1, scbc_pkg::SRC_FAST, 3'd4}; // R6
        else if (m == (scbc_pkg::CLKMD_DIV32 & scbc_pkg::CLKMD_SELMASK))
            decodeMode = {1'b1, scbc_pkg::SRC_FAST, 3'd5}; // R6
        else if (m == (scbc_pkg::CLKMD_SLOW & scbc_pkg::CLKMD_SELMASK))
            decodeMode = {1'b1, scbc_pkg::SRC_SLOW, 3'd0}; // R7
        else if ((m & scbc_pkg::CLKMD_XTALMSK) == scbc_pkg::CLKMD_XTAL)
            decodeMode = {1'b1, scbc_pkg::SRC_XTAL, 3'd0};
    endfunction : decodeMode

    function automatic logic [4:0] divTerm(input logic [2:0] lg);
        divTerm = 5'((6'd1 << lg) - 6'd1);
    endfunction : divTerm

    localparam logic [5:0] BOOT_SEL = decodeMode(BOOT_CLKMD);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    scbc_pkg::scbc_state_e state_ff;
    scbc_pkg::scbc_state_e nxt_state;
    logic [WAIT_W-1:0]     waitCnt_ff;
    logic [WAIT_W-1:0]     nxt_waitCnt;
    logic [7:0]            clkmd_ff;
    logic [7:0]            eoscr_ff;
    logic [7:0]            ihrcr_ff;
    logic                  fastWake_ff;
    logic [1:0]            selSrc_ff;
    logic [2:0]            selDiv_ff;
    logic [1:0]            actSrc_ff;
    logic [2:0]            actDiv_ff;
    logic [4:0]            divCnt_ff;
    logic [7:0]            regRdData_ff;
    logic                  fastRcEnable_ff;
    logic                  slowRcEnable_ff;
    logic                  crystalEnable_ff;
    logic                  sysClkTick_ff;
    logic                  cpuRun_ff;
    logic                  fetchStart_ff;
    logic [9:0]            fetchAddr_ff;
    logic                  wdtEnable_ff;
    logic                  portA5Input_ff;
    logic                  srcTick;
    logic                  suspWr;
    logic [5:0]            wrSel;

    assign suspWr = regWrStb && (regAddr == scbc_pkg::SUSP_ADDR) && (state_ff == scbc_pkg::ST_RUN);
    assign wrSel  = decodeMode(regWrData);

    always_comb
    begin
        case (actSrc_ff)
            scbc_pkg::SRC_FAST: srcTick = fastRcTick;
            scbc_pkg::SRC_SLOW: srcTick = slowRcTick;
            default:            srcTick = crystalTick;
        endcase
    end

    // -----------------------------------------------------------------
    // boot / suspend / wake sequencer
    // -----------------------------------------------------------------
    always_comb
    begin
        nxt_state   = state_ff;
        nxt_waitCnt = waitCnt_ff;
        case (state_ff)
            scbc_pkg::ST_BOOT:
            begin
                if (slowRcTick)
                begin
                    if (waitCnt_ff == WAIT_W'(scbc_pkg::BOOT_SLOW_CYC - 1)) // R1
                    begin
                        nxt_state   = scbc_pkg::ST_RUN;
                        nxt_waitCnt = '0;
                    end
                    else
                        nxt_waitCnt = waitCnt_ff + 1'b1;
                end
            end
            scbc_pkg::ST_RUN:
            begin
                if (suspWr && regWrData[scbc_pkg::SUSP_PDOWN_BIT])
                    nxt_state = scbc_pkg::ST_PDOWN;
                else if (suspWr && regWrData[scbc_pkg::SUSP_HALT_BIT])
                    nxt_state = scbc_pkg::ST_HALT;
            end
            scbc_pkg::ST_HALT:
            begin
                if (wakeEvent)
                    nxt_state = fastWake_ff ? scbc_pkg::ST_WAKESYS : scbc_pkg::ST_WAKESLOW; // R10 R12
            end
            scbc_pkg::ST_PDOWN:
            begin
                // fast wake only pays off when the fast RC drives the clock
                if (wakeEvent)
                    nxt_state = (fastWake_ff && actSrc_ff == scbc_pkg::SRC_FAST) ?
                                scbc_pkg::ST_SETTLE : scbc_pkg::ST_WAKESLOW; // R11 R12
            end
            scbc_pkg::ST_SETTLE:
            begin
                if (waitCnt_ff == WAIT_W'(scbc_pkg::FAST_RC_SETTLE_CYC - 1)) // R11
                begin
                    nxt_state   = scbc_pkg::ST_WAKESYS;
                    nxt_waitCnt = '0;
                end
                else
                    nxt_waitCnt = waitCnt_ff + 1'b1;
            end
            scbc_pkg::ST_WAKESYS:
            begin
                if (sysClkTick_ff)
                begin
                    if (waitCnt_ff == WAIT_W'(scbc_pkg::WAKE_SYS_CYC - 1)) // R10 R11
                    begin
                        nxt_state   = scbc_pkg::ST_RUN;
                        nxt_waitCnt = '0;
                    end
                    else
                        nxt_waitCnt = waitCnt_ff + 1'b1;
                end
            end
            scbc_pkg::ST_WAKESLOW:
            begin
                if (slowRcTick)
                begin
                    if (waitCnt_ff == WAIT_W'(scbc_pkg::WAKE_SLOW_CYC - 1)) // R12
                    begin
                        nxt_state   = scbc_pkg::ST_RUN;
                        nxt_waitCnt = '0;
                    end
                    else
                        nxt_waitCnt = waitCnt_ff + 1'b1;
                end
            end
            default:
            begin
                nxt_state   = scbc_pkg::ST_BOOT;
                nxt_waitCnt = '0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff   <= scbc_pkg::ST_BOOT;
            waitCnt_ff <= '0;
        end
        else
        begin
            state_ff   <= nxt_state;
            waitCnt_ff <= nxt_waitCnt;
        end
    end

    // -----------------------------------------------------------------
    // cpu start and boot straps
    // -----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            cpuRun_ff      <= 1'b0;
            fetchStart_ff  <= 1'b0;
            fetchAddr_ff   <= scbc_pkg::RESET_VECTOR;
            wdtEnable_ff   <= 1'b0;
            portA5Input_ff <= 1'b1; // R9
        end
        else
        begin
            cpuRun_ff     <= (nxt_state == scbc_pkg::ST_RUN);
            fetchStart_ff <= (state_ff == scbc_pkg::ST_BOOT) && (nxt_state == scbc_pkg::ST_RUN);
            if (state_ff == scbc_pkg::ST_BOOT)
            begin
                fetchAddr_ff <= scbc_pkg::RESET_VECTOR; // R2
                wdtEnable_ff <= (BOOT_CLKMD == scbc_pkg::CLKMD_SLOW); // R9
            end
        end
    end

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            clkmd_ff    <= BOOT_CLKMD; // R4 R9
            eoscr_ff    <= scbc_pkg::EOSCR_RST; // R4
            ihrcr_ff    <= scbc_pkg::IHRCR_RST;
            fastWake_ff <= 1'b0;
            selSrc_ff   <= BOOT_SEL[4:3];
            selDiv_ff   <= BOOT_SEL[2:0];
        end
        else if (regWrStb)
        begin
            if (regAddr == scbc_pkg::CLKMD_ADDR)
            begin
                clkmd_ff <= regWrData;
                if (wrSel[5]) // R14
                begin
                    selSrc_ff <= wrSel[4:3];
                    selDiv_ff <= wrSel[2:0];
                end
            end
            if (regAddr == scbc_pkg::EOSCR_ADDR)
                eoscr_ff <= regWrData;
            if (regAddr == scbc_pkg::IHRCR_ADDR)
                ihrcr_ff <= regWrData; // R8
            if (suspWr)
                fastWake_ff <= regWrData[scbc_pkg::SUSP_FAST_BIT];
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            regRdData_ff <= 8'h00;
        else if (regRdStb)
        begin
            case (regAddr)
                scbc_pkg::CLKMD_ADDR: regRdData_ff <= clkmd_ff;
                scbc_pkg::EOSCR_ADDR: regRdData_ff <= eoscr_ff;
                scbc_pkg::IHRCR_ADDR: regRdData_ff <= ihrcr_ff;
                scbc_pkg::SUSP_ADDR:  regRdData_ff <= {5'h00, fastWake_ff, 2'b00};
                scbc_pkg::STAT_ADDR:  regRdData_ff <= {actSrc_ff, cpuRun_ff, 2'b00, state_ff};
                default:              regRdData_ff <= 8'h00;
            endcase
        end
        else
            regRdData_ff <= 8'h00;
    end

    // -----------------------------------------------------------------
    // oscillator enables; everything stops in full power-down
    // -----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            fastRcEnable_ff  <= 1'b1; // R4
            slowRcEnable_ff  <= 1'b1; // R4
            crystalEnable_ff <= 1'b0; // R4
        end
        else
        begin
            fastRcEnable_ff  <= (nxt_state != scbc_pkg::ST_PDOWN) &&
                                clkmd_ff[scbc_pkg::CLKMD_FAST_EN_BIT]; // R3
            slowRcEnable_ff  <= (nxt_state != scbc_pkg::ST_PDOWN) &&
                                (clkmd_ff[scbc_pkg::CLKMD_SLOW_EN_BIT] ||
                                 nxt_state == scbc_pkg::ST_BOOT ||
                                 nxt_state == scbc_pkg::ST_WAKESLOW); // R3 R1 R12
            crystalEnable_ff <= (nxt_state != scbc_pkg::ST_PDOWN) &&
                                eoscr_ff[scbc_pkg::EOSCR_XTAL_EN_BIT]; // R3
        end
    end

    // -----------------------------------------------------------------
    // system clock divider; selection changes only between whole periods
    // -----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            actSrc_ff <= BOOT_SEL[4:3];
            actDiv_ff <= BOOT_SEL[2:0];
        end
        else if (divCnt_ff == 5'd0 && !srcTick) // R16
        begin
            actSrc_ff <= selSrc_ff; // R14
            actDiv_ff <= selDiv_ff;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            divCnt_ff     <= 5'd0;
            sysClkTick_ff <= 1'b0;
        end
        else
        begin
            sysClkTick_ff <= 1'b0;
            // no ticks while stopped or settling, so the 128 wake periods are counted on a stable clock
            if (srcTick && state_ff != scbc_pkg::ST_PDOWN && state_ff != scbc_pkg::ST_SETTLE) // R11
            begin
                if (divCnt_ff >= divTerm(actDiv_ff)) // R5 R6 R7
                begin
                    divCnt_ff     <= 5'd0;
                    sysClkTick_ff <= 1'b1;
                end
                else
                    divCnt_ff <= divCnt_ff + 5'd1;
            end
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign regRdData     = regRdData_ff;
    assign fastRcEnable  = fastRcEnable_ff;
    assign slowRcEnable  = slowRcEnable_ff;
    assign crystalEnable = crystalEnable_ff;
    assign crystalDrive  = eoscr_ff[scbc_pkg::EOSCR_DRV_LSB +: 2];
    assign fastRcTrim    = ihrcr_ff; // R8
    assign sysClkTick    = sysClkTick_ff;
    assign cpuRun        = cpuRun_ff;
    assign fetchStart    = fetchStart_ff;
    assign fetchAddr     = fetchAddr_ff;
    assign wdtEnable     = wdtEnable_ff;
    assign portA5Input   = portA5Input_ff;

endmodule : scbc_top

// [bench/scbc_top_properties.sv]
// Purpose: port-level checks of scbc_top
// Assumes: one clock domain, resetn active low
// Notes:   bound below
`timescale 1ns/100ps

module scbc_properties
(
    // clock and reset
    input wire logic       clock,
    input wire logic       resetn,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrStb,
    input wire logic       regRdStb,
    input wire logic [7:0] regRdData,
    // oscillators and wake
    input wire logic       fastRcTick,
    input wire logic       slowRcTick,
    input wire logic       crystalTick,
    input wire logic       wakeEvent,
    // oscillator control
    input wire logic       fastRcEnable,
    input wire logic       slowRcEnable,
    input wire logic       crystalEnable,
    input wire logic [1:0] crystalDrive,
    input wire logic [7:0] fastRcTrim,
    // system side
    input wire logic       sysClkTick,
    input wire logic       cpuRun,
    input wire logic       fetchStart,
    input wire logic [9:0] fetchAddr,
    input wire logic       wdtEnable,
    input wire logic       portA5Input
);
    logic [10:0] bootSlow_ff;
    logic        bootSeen_ff;
    logic        wrRun;

    assign wrRun = regWrStb && cpuRun;

    // -----------------------------------------------------------------
    // slow ticks since reset, frozen at the first fetch
    // -----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            bootSlow_ff <= 11'h000;
            bootSeen_ff <= 1'b0;
        end
        else
        begin
            if (slowRcTick && !bootSeen_ff && bootSlow_ff != 11'h7ff)
                bootSlow_ff <= bootSlow_ff + 11'h001;
            if (fetchStart)
                bootSeen_ff <= 1'b1;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    a_boot_delay: assert property (fetchStart && !bootSeen_ff |-> bootSlow_ff == 11'h400)
        else $error("first fetch not after boot tick count");
    a_fetch_vector: assert property (fetchStart |-> fetchAddr == scbc_pkg::RESET_VECTOR && cpuRun ##1 !fetchStart)
        else $error("first fetch address or pulse wrong");
    a_reset_state: assert property ($rose(resetn) |-> fastRcEnable && slowRcEnable && !crystalEnable && portA5Input && !cpuRun)
        else $error("state after reset release wrong");
    a_boot_outputs: assert property (fetchStart && !bootSeen_ff |-> fastRcEnable && slowRcEnable && !crystalEnable && !wdtEnable && portA5Input)
        else $error("state after boot wrong");
    a_xtal_enable: assert property (wrRun && regAddr == scbc_pkg::EOSCR_ADDR |-> ##3 crystalEnable == $past(regWrData[7], 3))
        else $error("crystal enable does not follow write");
    a_rc_enables: assert property (wrRun && regAddr == scbc_pkg::CLKMD_ADDR |-> ##3 fastRcEnable == $past(regWrData[4], 3) && slowRcEnable == $past(regWrData[2], 3))
        else $error("rc enables do not follow mode write");
    a_trim_write: assert property (regWrStb && regAddr == scbc_pkg::IHRCR_ADDR |=> fastRcTrim == $past(regWrData))
        else $error("trim value not taken");
    a_tick_aligned: assert property (sysClkTick |-> $past(fastRcTick) || $past(slowRcTick) || $past(crystalTick))
        else $error("system tick without source tick");
    a_halt_stops: assert property (wrRun && regAddr == scbc_pkg::SUSP_ADDR && regWrData[0] |-> ##[1:2] !cpuRun)
        else $error("cpu still running after halt");
    a_pdown_gates: assert property (wrRun && regAddr == scbc_pkg::SUSP_ADDR && regWrData[1] |-> ##2 !fastRcEnable && !crystalEnable)
        else $error("oscillators running in power-down");

    c_boot: cover property (fetchStart);
    c_wake: cover property (bootSeen_ff && $rose(cpuRun));
    c_slow: cover property (regWrStb && regAddr == scbc_pkg::CLKMD_ADDR && regWrData == scbc_pkg::CLKMD_SLOW);
endmodule : scbc_properties

bind scbc_top scbc_properties u_props (.*);

// [bench/scbc_top_tb.sv]
// Purpose: self-checking bench of scbc_top
// Assumes: oscillators modelled as tick pulses, fast ticks random
// Notes:   slow tick every 4 clocks keeps the 1024-tick waits short
`timescale 1ns/100ps

module scbc_top_tb;
    logic clock, resetn, regWrStb, regRdStb, fastRcTick, slowRcTick, crystalTick, wakeEvent, srcTick;
    logic fastRcEnable, slowRcEnable, crystalEnable, sysClkTick, cpuRun, fetchStart, wdtEnable, portA5Input;
    logic [7:0] regAddr, regWrData, regRdData, fastRcTrim, rdVal, dat;
    logic [1:0] crystalDrive, srcSel;
    logic [9:0] fetchAddr;
    logic [7:0] modeTab [8];
    logic [7:0] suspTab [4];
    int fail_count, samples_checked, seed, cyc, gap, tickCnt, nSys, nSlow, nCyc;

    scbc_top dut (.*);

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // -----------------------------------------------------------------
    // oscillator ticks and system period monitor
    // -----------------------------------------------------------------
    assign srcTick = (srcSel == 2'h0) ? fastRcTick : (srcSel == 2'h1) ? slowRcTick : crystalTick;

    always @(posedge clock)
    begin
        cyc         <= cyc + 1;
        fastRcTick  <= 1'($random(seed));
        slowRcTick  <= (cyc % 4 == 0);
        crystalTick <= (cyc % 3 == 1);
        if (sysClkTick === 1'b1)
        begin
            gap     <= tickCnt;
            tickCnt <= int'(srcTick);
        end
        else
            tickCnt <= tickCnt + int'(srcTick);
    end

    // -----------------------------------------------------------------
    // tasks
    // -----------------------------------------------------------------
    task automatic close_out();
        if (fail_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr   <= a;
        regWrData <= d;
        regWrStb  <= 1'b1;
        @(posedge clock);
        regWrStb  <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        regAddr  <= a;
        regRdStb <= 1'b1;
        @(posedge clock);
        regRdStb <= 1'b0;
        #1 d = regRdData;
    endtask : rd

    task automatic runUntil(input logic useFetch);
        nSys = 0;
        nSlow = 0;
        nCyc = 0;
        while ((useFetch ? fetchStart : cpuRun) !== 1'b1 && nCyc < 20000)
        begin
            nSys  += int'(sysClkTick === 1'b1);
            nSlow += int'(slowRcTick);
            nCyc++;
            tick(1);
        end
        if (nCyc >= 20000)
        begin
            fail_count++;
            close_out();
        end
    endtask : runUntil

    task automatic doReset();
        @(posedge clock);
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        #1;
        check({fastRcEnable, slowRcEnable, crystalEnable, portA5Input, cpuRun}, 5'h1_a);
        check(fastRcTrim, scbc_pkg::IHRCR_RST);
        runUntil(1'b1);
        check(nSlow, scbc_pkg::BOOT_SLOW_CYC);
        check(fetchAddr, scbc_pkg::RESET_VECTOR);
        check({wdtEnable, portA5Input, slowRcEnable}, 3'h3);
    endtask : doReset

    task automatic waitSys(input int n);
        int k;
        k = 0;
        while (n > 0 && k < 5000)
        begin
            tick(1);
            n -= int'(sysClkTick === 1'b1);
            k++;
        end
        if (n > 0)
        begin
            fail_count++;
            close_out();
        end
        tick(1);
    endtask : waitSys

    function automatic int expGap(input logic [7:0] m);
        case (m)
            scbc_pkg::CLKMD_DIV2:  return 2;
            scbc_pkg::CLKMD_DIV4:  return 4;
            scbc_pkg::CLKMD_DIV8:  return 8;
            scbc_pkg::CLKMD_DIV16: return 16;
            scbc_pkg::CLKMD_DIV32: return 32;
            default:               return 1;
        endcase
    endfunction : expGap

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial
    begin
        {seed, cyc, gap, tickCnt, fail_count, samples_checked} = {32'd40, 160'd0};
        {resetn, regWrStb, regRdStb, fastRcTick, slowRcTick, crystalTick, wakeEvent} = 7'h00;
        {regAddr, regWrData, srcSel} = 18'h0_0000;
        modeTab = '{8'h34, 8'h14, 8'h3c, 8'h1c, 8'h7c, 8'hf4, 8'he4, 8'hb4};
        suspTab = '{8'h05, 8'h01, 8'h02, 8'h06};
        doReset();
        rd(scbc_pkg::CLKMD_ADDR, rdVal);
        check(rdVal, scbc_pkg::CLKMD_DIV2);
        rd(8'h7f, rdVal);
        check(rdVal, 8'h00);
        repeat (4)
        begin
            dat = 8'($random(seed));
            wr(scbc_pkg::IHRCR_ADDR, dat);
            rd(scbc_pkg::IHRCR_ADDR, rdVal);
            check({fastRcTrim, rdVal}, {dat, dat});
        end
        wr(scbc_pkg::EOSCR_ADDR, 8'he0);
        tick(2);
        check({crystalEnable, crystalDrive}, 3'h7);
        // each switch keeps the old oscillator on; the fast RC is stopped a write later, the slow RC stays on
        foreach (modeTab[i])
        begin
            srcSel <= (modeTab[i][7:5] == 3'h7) ? 2'h1 : (modeTab[i][7:5] == 3'h5) ? 2'h2 : 2'h0;
            wr(scbc_pkg::CLKMD_ADDR, modeTab[i]);
            rd(scbc_pkg::CLKMD_ADDR, rdVal);
            check(rdVal, modeTab[i]);
            check({fastRcEnable, slowRcEnable}, {modeTab[i][4], modeTab[i][2]});
            waitSys(3);
            check(gap, expGap(modeTab[i]));
        end
        srcSel <= 2'h0;
        wr(scbc_pkg::CLKMD_ADDR, scbc_pkg::CLKMD_DIV2);
        wr(scbc_pkg::EOSCR_ADDR, 8'h00);
        foreach (suspTab[i])
        begin
            wr(scbc_pkg::SUSP_ADDR, suspTab[i]);
            tick(4);
            check(cpuRun, 1'b0);
            if (suspTab[i][1])
                check({fastRcEnable, crystalEnable}, 2'h0);
            @(posedge clock);
            wakeEvent <= 1'b1;
            @(posedge clock);
            wakeEvent <= 1'b0;
            #1;
            runUntil(1'b0);
            if (suspTab[i][2])
                check(nSys, scbc_pkg::WAKE_SYS_CYC);
            else
                check(nSlow, scbc_pkg::WAKE_SLOW_CYC);
            if (suspTab[i] == 8'h06)
                check(nCyc > scbc_pkg::FAST_RC_SETTLE_CYC, 1'b1);
        end
        doReset();
        close_out();
    end
endmodule : scbc_top_tb
